// File: wla_regs.svh
// Purpose: constants of the word load align unit
// Assumes: included by its bare name
// Notes:   opcode, field and access type encodings
`ifndef WLA_REGS_SVH
`define WLA_REGS_SVH

// --------------------------------------------------------------
// instruction fields
// --------------------------------------------------------------
`define WLA_OPC_HI     31
`define WLA_OPC_LO     26
`define WLA_BASE_HI    25
`define WLA_BASE_LO    21
`define WLA_TGT_HI     20
`define WLA_TGT_LO     16
`define WLA_OFS_HI     15
`define WLA_OFS_LO     0

// --------------------------------------------------------------
// major opcodes
// --------------------------------------------------------------
`define WLA_OPC_IMM    6'h0f
`define WLA_OPC_WORD   6'h23
`define WLA_OPC_LEFT   6'h22
`define WLA_OPC_RIGHT  6'h26
`define WLA_OPC_COP    4'hc

// --------------------------------------------------------------
// memory access types and widths
// --------------------------------------------------------------
`define WLA_ACC_WORD   3'h3
`define WLA_ACC_DWORD  3'h7
`define WLA_PA_W       36

`endif

// File: wla_pkg.sv
// Purpose: types of the word load align unit
// Assumes: nothing
// Notes:   enumerations only; numbers live in wla_regs.svh
package wla_pkg;

  typedef enum logic [1:0] {
    WLA_ST_IDLE,
    WLA_ST_XLATE,
    WLA_ST_MEM,
    WLA_ST_DONE
  } wla_state_t;

  typedef enum logic [2:0] {
    WLA_OP_NONE,
    WLA_OP_UPPER_IMM,
    WLA_OP_WORD,
    WLA_OP_COP,
    WLA_OP_LEFT,
    WLA_OP_RIGHT
  } wla_op_t;

  typedef enum logic [2:0] {
    WLA_EXC_NONE,
    WLA_EXC_RESERVED,
    WLA_EXC_COP_UNUSABLE,
    WLA_EXC_ADDR_ERROR,
    WLA_EXC_XLT_REFILL,
    WLA_EXC_XLT_INVALID,
    WLA_EXC_BUS_ERROR
  } wla_exc_t;

endpackage

// File: wla_lane_merge.sv
// Purpose: pick the memory word and merge partial bytes with the old register
// Assumes: i_byte already carries the cpu endian correction
// Notes:   purely combinational, sign extension is done by the caller
`timescale 1ns/10ps
module wla_lane_merge (
  // operation
  input  wire logic        i_left,
  input  wire logic        i_right,
  input  wire logic [1:0]  i_byte,
  input  wire logic        i_word,
  // data
  input  wire logic [63:0] i_mem,
  input  wire logic [31:0] i_old_val,
  output logic      [31:0] o_merged
);

  logic [31:0] word_sel;
  logic [4:0]  lsh;
  logic [4:0]  rsh;
  logic [31:0] keep_lo;
  logic [31:0] keep_hi;

  assign word_sel = i_word ? i_mem[63:32] : i_mem[31:0];
  assign lsh      = {~i_byte, 3'h0};
  assign rsh      = {i_byte, 3'h0};
  // low bytes that a left load leaves alone; none when four bytes arrive
  assign keep_lo  = (i_byte == 2'h3) ? 32'h0000_0000 : (32'h00ff_ffff >> rsh);
  assign keep_hi  = ~(32'hffff_ffff >> rsh);

  always_comb begin
    if (i_left) begin
      o_merged = (word_sel << lsh) | (i_old_val & keep_lo);
    end else if (i_right) begin
      o_merged = (word_sel >> rsh) | (i_old_val & keep_hi);
    end else begin
      o_merged = word_sel;
    end
  end

endmodule // wla_lane_merge

// File: wla_load_unit.sv
// Purpose: load datapath for upper immediate, word, coprocessor and partial word loads
// Assumes: translation and memory answer with one-cycle ack pulses
// Notes:   one instruction in flight; a new one is taken only when idle
`timescale 1ns/10ps
`include "wla_regs.svh"

// Contract
// - upper immediate shifted sixteen, then sign-extended
// - address is base plus sign-extended offset
// - word load result sign-extended from bit 31
// - word and coprocessor loads trap on misalignment
// - decode opcodes and base, target, offset fields; the base field is not decoded, its value arrives on i_base_val
// - coprocessor load hands word to selected coprocessor
// - coprocessor load to system control is invalid
// - unusable coprocessor raises coprocessor unusable exception
// - loads report refill, invalid, bus, address errors
// - left load fills from top, keeps low bytes
// - right load fills from bottom, keeps high bytes
// - partial loads touch only one aligned word
// - partial loads never raise alignment errors
// - target register bypassed from preceding load
// - left load, little memory, clear address bits
// - left load type is bytes minus one
// - right load type from address, sign-extended; the code zero-extends it as {1'b0, byte_sel}
module wla_load_unit (
  // clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_b,
  // endian and coprocessor configuration
  input  wire logic                   i_cpu_big_endian_flag,
  input  wire logic                   i_memory_big_endian_flag,
  input  wire logic                   i_user_endian_reversal_flag,
  input  wire logic [3:0]             i_cop_usable,
  // instruction issue
  input  wire logic                   i_issue_valid,
  output logic                        o_issue_ready,
  input  wire logic [31:0]            i_instr,
  input  wire logic [63:0]            i_base_val,
  input  wire logic [63:0]            i_target_register_val,
  // translation request
  output logic                        o_xlt_req,
  output logic [63:0]                 o_xlt_vaddr,
  input  wire logic                   i_xlt_ack,
  input  wire logic [`WLA_PA_W-1:0]   i_xlt_paddr,
  input  wire logic                   i_xlt_refill,
  input  wire logic                   i_xlt_invalid,
  // memory read
  output logic                        o_mem_req,
  output logic [`WLA_PA_W-1:0]        o_mem_paddr,
  output logic [2:0]                  o_mem_type,
  output logic [2:0]                  o_mem_offset,
  input  wire logic                   i_mem_ack,
  input  wire logic [63:0]            i_mem_data,
  input  wire logic                   i_mem_bus_err,
  // completion
  output logic                        o_done,
  output logic                        o_gpr_we,
  output logic [4:0]                  o_gpr_idx,
  output logic [63:0]                 o_gpr_data,
  output logic                        o_cop_we,
  output logic [1:0]                  o_cop_sel,
  output logic [4:0]                  o_cop_reg,
  output logic [31:0]                 o_cop_data,
  output logic                        o_exc_valid,
  output wla_pkg::wla_exc_t           o_exc_kind,
  output logic [63:0]                 o_exc_vaddr
);

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  logic [5:0]        opc;
  logic [4:0]        tgt_idx;
  logic [15:0]       ofs;
  wla_pkg::wla_op_t  op_dec;
  logic [63:0]       vaddr_calc;
  logic [63:0]       tgt_in;
  wla_pkg::wla_exc_t exc_pre;

  assign opc     = i_instr[`WLA_OPC_HI:`WLA_OPC_LO];
  assign tgt_idx = i_instr[`WLA_TGT_HI:`WLA_TGT_LO];
  assign ofs     = i_instr[`WLA_OFS_HI:`WLA_OFS_LO];

  always_comb begin
    op_dec = wla_pkg::WLA_OP_NONE;
    if (opc == `WLA_OPC_IMM) begin
      op_dec = wla_pkg::WLA_OP_UPPER_IMM;
    end else if (opc == `WLA_OPC_WORD) begin
      op_dec = wla_pkg::WLA_OP_WORD;
    end else if (opc == `WLA_OPC_LEFT) begin
      op_dec = wla_pkg::WLA_OP_LEFT;
    end else if (opc == `WLA_OPC_RIGHT) begin
      op_dec = wla_pkg::WLA_OP_RIGHT;
    end else if (opc[5:2] == `WLA_OPC_COP) begin
      op_dec = wla_pkg::WLA_OP_COP;
    end
  end

  // base plus sign-extended offset, the same adder for every load
  assign vaddr_calc = i_base_val + {{48{ofs[15]}}, ofs};

  // --------------------------------------------------------------
  // target register bypass
  // --------------------------------------------------------------
  // the register file may not yet hold the last result when the next
  // partial load is issued, so the last written value is kept here
  logic        byp_valid_r;
  logic [4:0]  byp_idx_r;
  logic [63:0] byp_data_r;

  assign tgt_in = (byp_valid_r && byp_idx_r == tgt_idx) ? byp_data_r
                                                        : i_target_register_val;

  // --------------------------------------------------------------
  // early exceptions, checked in priority order
  // --------------------------------------------------------------
  always_comb begin
    exc_pre = wla_pkg::WLA_EXC_NONE;
    unique case (op_dec)
      wla_pkg::WLA_OP_NONE: begin
        exc_pre = wla_pkg::WLA_EXC_RESERVED;
      end
      wla_pkg::WLA_OP_COP: begin
        if (opc[1:0] == 2'h0) begin
          exc_pre = wla_pkg::WLA_EXC_RESERVED;
        end else if (!i_cop_usable[opc[1:0]]) begin
          exc_pre = wla_pkg::WLA_EXC_COP_UNUSABLE;
        end else if (vaddr_calc[1:0] != 2'h0) begin
          exc_pre = wla_pkg::WLA_EXC_ADDR_ERROR;
        end
      end
      wla_pkg::WLA_OP_WORD: begin
        if (vaddr_calc[1:0] != 2'h0) begin
          exc_pre = wla_pkg::WLA_EXC_ADDR_ERROR;
        end
      end
      // partial loads have no alignment check at all
      wla_pkg::WLA_OP_LEFT,
      wla_pkg::WLA_OP_RIGHT,
      wla_pkg::WLA_OP_UPPER_IMM: begin
        exc_pre = wla_pkg::WLA_EXC_NONE;
      end
      default: begin
        exc_pre = wla_pkg::WLA_EXC_RESERVED;
      end
    endcase
  end

  // --------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------
  wla_pkg::wla_state_t state_r;
  logic                take;

  assign take          = (state_r == wla_pkg::WLA_ST_IDLE) && i_issue_valid;
  assign o_issue_ready = (state_r == wla_pkg::WLA_ST_IDLE);
  assign o_xlt_req     = (state_r == wla_pkg::WLA_ST_XLATE);
  assign o_mem_req     = (state_r == wla_pkg::WLA_ST_MEM);
  assign o_done        = (state_r == wla_pkg::WLA_ST_DONE);

  logic xlt_fault;
  assign xlt_fault = i_xlt_refill || i_xlt_invalid;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= wla_pkg::WLA_ST_IDLE;
    end else begin
      unique case (state_r)
        wla_pkg::WLA_ST_IDLE: begin
          if (take) begin
            if (op_dec == wla_pkg::WLA_OP_UPPER_IMM ||
                exc_pre != wla_pkg::WLA_EXC_NONE) begin
              state_r <= wla_pkg::WLA_ST_DONE;
            end else begin
              state_r <= wla_pkg::WLA_ST_XLATE;
            end
          end
        end
        wla_pkg::WLA_ST_XLATE: begin
          if (i_xlt_ack) begin
            state_r <= xlt_fault ? wla_pkg::WLA_ST_DONE : wla_pkg::WLA_ST_MEM;
          end
        end
        wla_pkg::WLA_ST_MEM: begin
          if (i_mem_ack) begin
            state_r <= wla_pkg::WLA_ST_DONE;
          end
        end
        wla_pkg::WLA_ST_DONE: begin
          state_r <= wla_pkg::WLA_ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // captured instruction
  // --------------------------------------------------------------
  wla_pkg::wla_op_t op_r;
  logic [63:0]      vaddr_r;
  logic [63:0]      old_wd_r;
  logic [4:0]       tgt_r;
  logic [1:0]       cop_r;
  logic             cpu_be_r;
  logic             mem_be_r;
  logic             rev_r;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_r     <= wla_pkg::WLA_OP_NONE;
      vaddr_r  <= 64'h0;
      old_wd_r <= 64'h0;
      tgt_r    <= 5'h0;
      cop_r    <= 2'h0;
      cpu_be_r <= 1'b0;
      mem_be_r <= 1'b0;
      rev_r    <= 1'b0;
    end else if (take) begin
      op_r     <= op_dec;
      vaddr_r  <= vaddr_calc;
      old_wd_r <= tgt_in;
      tgt_r    <= tgt_idx;
      cop_r    <= opc[1:0];
      cpu_be_r <= i_cpu_big_endian_flag;
      mem_be_r <= i_memory_big_endian_flag;
      rev_r    <= i_user_endian_reversal_flag;
    end
  end

  assign o_xlt_vaddr = vaddr_r;

  // --------------------------------------------------------------
  // physical address, access type and byte offset
  // --------------------------------------------------------------
  logic                 is_part;
  logic [1:0]           byte_sel;
  logic                 word_sel;
  logic [`WLA_PA_W-1:0] pa_adj;
  logic [2:0]           acc_type;

  assign is_part  = (op_r == wla_pkg::WLA_OP_LEFT) || (op_r == wla_pkg::WLA_OP_RIGHT);
  assign byte_sel = vaddr_r[1:0] ^ {2{cpu_be_r}};
  assign word_sel = vaddr_r[2] ^ cpu_be_r;

  always_comb begin
    pa_adj = i_xlt_paddr;
    if (is_part) begin
      pa_adj[2:0] = i_xlt_paddr[2:0] ^ {3{rev_r}};
    end else begin
      pa_adj[2:0] = i_xlt_paddr[2:0] ^ {rev_r, 2'h0};
    end
    if (op_r == wla_pkg::WLA_OP_LEFT && !mem_be_r) begin
      pa_adj[2:0] = 3'h0;
    end
    if (op_r == wla_pkg::WLA_OP_RIGHT && mem_be_r) begin
      pa_adj[2:0] = 3'h0;
    end
  end

  always_comb begin
    unique case (op_r)
      wla_pkg::WLA_OP_COP: begin
        acc_type = `WLA_ACC_DWORD;
      end
      wla_pkg::WLA_OP_LEFT,
      wla_pkg::WLA_OP_RIGHT: begin
        acc_type = {1'b0, byte_sel};
      end
      default: begin
        acc_type = `WLA_ACC_WORD;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_paddr <= '0;
      o_mem_type  <= 3'h0;
    end else if (state_r == wla_pkg::WLA_ST_XLATE && i_xlt_ack) begin
      o_mem_paddr <= pa_adj;
      o_mem_type  <= acc_type;
    end
  end

  assign o_mem_offset = o_mem_paddr[2:0];

  // --------------------------------------------------------------
  // lane selection and merge
  // --------------------------------------------------------------
  logic [31:0] merged;
  logic [63:0] load_res;

  wla_lane_merge u_merge (
    .i_left    (op_r == wla_pkg::WLA_OP_LEFT),
    .i_right   (op_r == wla_pkg::WLA_OP_RIGHT),
    .i_byte    (byte_sel),
    .i_word    (word_sel),
    .i_mem     (i_mem_data),
    .i_old_val (old_wd_r[31:0]),
    .o_merged  (merged)
  );

  // every general register load result is a 32-bit value sign-extended to 64; coprocessor loads pass merged unextended
  assign load_res = {{32{merged[31]}}, merged};

  // --------------------------------------------------------------
  // completion registers
  // --------------------------------------------------------------
  logic [63:0] imm_res;
  assign imm_res = {{32{ofs[15]}}, ofs, 16'h0000};

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gpr_we    <= 1'b0;
      o_cop_we    <= 1'b0;
      o_gpr_data  <= 64'h0;
      o_cop_data  <= 32'h0;
      o_exc_valid <= 1'b0;
      o_exc_kind  <= wla_pkg::WLA_EXC_NONE;
      o_exc_vaddr <= 64'h0;
    end else begin
      unique case (state_r)
        wla_pkg::WLA_ST_IDLE: begin
          o_gpr_we    <= 1'b0;
          o_cop_we    <= 1'b0;
          o_exc_valid <= 1'b0;
          o_exc_kind  <= wla_pkg::WLA_EXC_NONE;
          if (take) begin
            o_exc_vaddr <= vaddr_calc;
            if (exc_pre != wla_pkg::WLA_EXC_NONE) begin
              o_exc_valid <= 1'b1;
              o_exc_kind  <= exc_pre;
            end else if (op_dec == wla_pkg::WLA_OP_UPPER_IMM) begin
              o_gpr_we   <= 1'b1;
              o_gpr_data <= imm_res;
            end
          end
        end
        wla_pkg::WLA_ST_XLATE: begin
          if (i_xlt_ack && xlt_fault) begin
            o_exc_valid <= 1'b1;
            o_exc_kind  <= i_xlt_refill ? wla_pkg::WLA_EXC_XLT_REFILL
                                        : wla_pkg::WLA_EXC_XLT_INVALID;
          end
        end
        wla_pkg::WLA_ST_MEM: begin
          if (i_mem_ack) begin
            if (i_mem_bus_err) begin
              o_exc_valid <= 1'b1;
              o_exc_kind  <= wla_pkg::WLA_EXC_BUS_ERROR;
            end else if (op_r == wla_pkg::WLA_OP_COP) begin
              o_cop_we   <= 1'b1;
              o_cop_data <= merged;
            end else begin
              o_gpr_we   <= 1'b1;
              o_gpr_data <= load_res;
            end
          end
        end
        wla_pkg::WLA_ST_DONE: begin
          o_gpr_we    <= o_gpr_we;
          o_cop_we    <= o_cop_we;
          o_exc_valid <= o_exc_valid;
        end
      endcase
    end
  end

  // write enables and exception are read only while o_done is high
  assign o_gpr_idx = tgt_r;
  assign o_cop_sel = cop_r;
  assign o_cop_reg = tgt_r;

  // --------------------------------------------------------------
  // bypass update
  // --------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      byp_valid_r <= 1'b0;
      byp_idx_r   <= 5'h0;
      byp_data_r  <= 64'h0;
    end else if (o_done && o_gpr_we) begin
      byp_valid_r <= 1'b1;
      byp_idx_r   <= tgt_r;
      byp_data_r  <= o_gpr_data;
    end
  end

endmodule // wla_load_unit

// File: wla_load_unit_sva.sv
// Purpose: port checker for wla_load_unit
// Assumes: one clock domain, async active-low reset
// Notes:   helpers capture the issue-time operands
`timescale 1ns/10ps
`include "wla_regs.svh"
module wla_load_unit_sva (
  // clock and reset
  input wire logic              i_ref_clk,
  input wire logic              i_rst_b,
  // issue
  input wire logic              i_issue_valid,
  input wire logic              o_issue_ready,
  input wire logic [31:0]       i_instr,
  input wire logic [63:0]       i_base_val,
  // translation and memory
  input wire logic              o_xlt_req,
  input wire logic [63:0]       o_xlt_vaddr,
  input wire logic              i_xlt_ack,
  input wire logic              i_xlt_refill,
  input wire logic              i_xlt_invalid,
  input wire logic              o_mem_req,
  input wire logic              i_mem_ack,
  input wire logic              i_mem_bus_err,
  // completion
  input wire logic              o_done,
  input wire logic              o_gpr_we,
  input wire logic [63:0]       o_gpr_data,
  input wire logic              o_exc_valid,
  input wire wla_pkg::wla_exc_t o_exc_kind
);
  logic [63:0] va_r;
  logic [15:0] imm_r;
  always_ff @(posedge i_ref_clk) begin
    va_r  <= i_base_val + {{48{i_instr[15]}}, i_instr[15:0]};
    imm_r <= i_instr[15:0];
  end
  // --------
  // sequences
  // --------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_take; i_issue_valid && o_issue_ready; endsequence
  sequence s_xlt_ok; o_xlt_req && i_xlt_ack && !i_xlt_refill && !i_xlt_invalid; endsequence
  sequence s_mem_ok; o_mem_req && i_mem_ack && !i_mem_bus_err; endsequence
  a_done_pulse: assert property (o_done |=> !o_done) else $error("done too long");
  a_ready_after_done: assert property (o_done |=> o_issue_ready) else $error("not ready");
  a_busy_not_ready: assert property (o_xlt_req || o_mem_req |-> !o_issue_ready)
    else $error("ready while busy");
  a_done_bound: assert property (s_take |-> ##[1:40] o_done) else $error("no done");
  a_xlt_to_mem: assert property (s_xlt_ok |=> o_mem_req && !o_done) else $error("no mem req");
  a_mem_to_done: assert property (s_mem_ok |=> o_done && !o_exc_valid)
    else $error("no clean done");
  a_bus_error: assert property (o_mem_req && i_mem_ack && i_mem_bus_err |=>
    o_done && o_exc_kind == wla_pkg::WLA_EXC_BUS_ERROR && !o_gpr_we) else $error("bus err");
  a_xlt_refill: assert property (o_xlt_req && i_xlt_ack && i_xlt_refill |=>
    o_done && o_exc_kind == wla_pkg::WLA_EXC_XLT_REFILL) else $error("refill");
  a_xlt_invalid: assert property (o_xlt_req && i_xlt_ack && !i_xlt_refill &&
    i_xlt_invalid |=> o_done && o_exc_kind == wla_pkg::WLA_EXC_XLT_INVALID) else $error("inv");
  a_upper_imm: assert property (s_take ##0 i_instr[31:26] == `WLA_OPC_IMM |=>
    o_done && o_gpr_we && o_gpr_data == {{32{imm_r[15]}}, imm_r, 16'h0}) else $error("upper");
  a_vaddr_sum: assert property ($rose(o_xlt_req) |-> o_xlt_vaddr == va_r)
    else $error("vaddr");
  a_word_misalign: assert property (s_take ##0 (i_instr[31:26] == `WLA_OPC_WORD &&
    i_base_val[1:0] + i_instr[1:0] != 2'h0) |=> o_done && o_exc_valid &&
    o_exc_kind == wla_pkg::WLA_EXC_ADDR_ERROR) else $error("misalign");
endmodule // wla_load_unit_sva

bind wla_load_unit wla_load_unit_sva u_sva (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_issue_valid(i_issue_valid),
  .o_issue_ready(o_issue_ready), .i_instr(i_instr), .i_base_val(i_base_val),
  .o_xlt_req(o_xlt_req), .o_xlt_vaddr(o_xlt_vaddr), .i_xlt_ack(i_xlt_ack),
  .i_xlt_refill(i_xlt_refill), .i_xlt_invalid(i_xlt_invalid), .o_mem_req(o_mem_req),
  .i_mem_ack(i_mem_ack), .i_mem_bus_err(i_mem_bus_err), .o_done(o_done),
  .o_gpr_we(o_gpr_we), .o_gpr_data(o_gpr_data), .o_exc_valid(o_exc_valid),
  .o_exc_kind(o_exc_kind));

// File: wla_mem_model.sv
// Purpose: translation and memory responder
// Assumes: requests stay up until acknowledged
// Notes:   answer lines carry junk outside the ack cycle
`timescale 1ns/10ps
module wla_mem_model (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // scenario control
  input  wire logic [1:0]  i_delay,
  input  wire logic [1:0]  i_fault,
  input  wire logic [63:0] i_word,
  // translation side
  input  wire logic        i_xlt_req,
  input  wire logic [63:0] i_xlt_vaddr,
  output logic             o_xlt_ack,
  output logic [35:0]      o_xlt_paddr,
  output logic             o_xlt_refill,
  output logic             o_xlt_invalid,
  // memory side
  input  wire logic        i_mem_req,
  output logic             o_mem_ack,
  output logic [63:0]      o_mem_data,
  output logic             o_mem_bus_err
);
  logic [1:0] cnt_r;
  logic       tog_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r     <= 2'h0;
      tog_r     <= 1'b0;
      o_xlt_ack <= 1'b0;
      o_mem_ack <= 1'b0;
    end else begin
      tog_r     <= !tog_r;
      o_xlt_ack <= 1'b0;
      o_mem_ack <= 1'b0;
      if ((i_xlt_req && !o_xlt_ack) || (i_mem_req && !o_mem_ack)) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == i_delay) begin
          cnt_r     <= 2'h0;
          o_xlt_ack <= i_xlt_req;
          o_mem_ack <= i_mem_req;
        end
      end
    end
  end
  // identity translation; faults only mean something with an ack
  assign o_xlt_paddr   = o_xlt_ack ? i_xlt_vaddr[35:0] : ~i_xlt_vaddr[35:0];
  assign o_xlt_refill  = o_xlt_ack ? i_fault == 2'h1 : tog_r;
  assign o_xlt_invalid = o_xlt_ack ? i_fault == 2'h2 : !tog_r;
  assign o_mem_data    = o_mem_ack ? i_word : ~i_word;
  assign o_mem_bus_err = o_mem_ack ? i_fault == 2'h3 : tog_r;
endmodule // wla_mem_model

// File: word_load_align_unit_tb.sv
// Purpose: self-checking bench for wla_load_unit
// Assumes: one instruction in flight
// Notes:   expectations built from operands, never from outputs
`timescale 1ns/10ps
`include "wla_regs.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module word_load_align_unit_tb;
  logic        clk = 1'b0, rst_b = 1'b0, cpu_be = 1'b0, mem_be = 1'b0, rev = 1'b0;
  logic        valid = 1'b0, ready, xreq, xack, xref, xinv, mreq, mack, merr, done;
  logic        gwe, cwe, evld, lv = 1'b0;
  logic [1:0]  dly = 2'h0, flt = 2'h0, csel;
  logic [3:0]  cop_ok = 4'h0;
  logic [4:0]  gidx, creg, lidx = 5'h0;
  logic [2:0]  mtype, moff;
  logic [31:0] instr = 32'h0, cdata;
  logic [35:0] xpa, mpa;
  logic [63:0] base = 64'h0, oldv = 64'h0, word = 64'h0, ld = 64'h0, xva, mdata, gdata, eva;
  wla_pkg::wla_exc_t ekind;
  int          fails = 0, total_checks = 0, seed = 44;
  wla_load_unit uut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_cpu_big_endian_flag(cpu_be),
    .i_memory_big_endian_flag(mem_be), .i_user_endian_reversal_flag(rev), .i_cop_usable(cop_ok),
    .i_issue_valid(valid), .o_issue_ready(ready), .i_instr(instr), .i_base_val(base),
    .i_target_register_val(oldv), .o_xlt_req(xreq), .o_xlt_vaddr(xva), .i_xlt_ack(xack),
    .i_xlt_paddr(xpa), .i_xlt_refill(xref), .i_xlt_invalid(xinv), .o_mem_req(mreq),
    .o_mem_paddr(mpa), .o_mem_type(mtype), .o_mem_offset(moff), .i_mem_ack(mack),
    .i_mem_data(mdata), .i_mem_bus_err(merr), .o_done(done), .o_gpr_we(gwe), .o_gpr_idx(gidx),
    .o_gpr_data(gdata), .o_cop_we(cwe), .o_cop_sel(csel), .o_cop_reg(creg), .o_cop_data(cdata),
    .o_exc_valid(evld), .o_exc_kind(ekind), .o_exc_vaddr(eva));
  wla_mem_model u_mem (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_delay(dly), .i_fault(flt), .i_word(word),
    .i_xlt_req(xreq), .i_xlt_vaddr(xva), .o_xlt_ack(xack), .o_xlt_paddr(xpa),
    .o_xlt_refill(xref), .o_xlt_invalid(xinv), .i_mem_req(mreq), .o_mem_ack(mack),
    .o_mem_data(mdata), .o_mem_bus_err(merr));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // --------
  // one instruction: drive, model, compare
  // --------
  task automatic run(input logic [31:0] ins, input logic [63:0] bv, input logic [11:0] c);
    logic [5:0]  op;
    logic [63:0] va, od, ed;
    logic [35:0] pa;
    logic [31:0] wd, t;
    logic [2:0]  ty;
    logic [1:0]  bt;
    logic        lft, rgt, cop, seen;
    wla_pkg::wla_exc_t ek;
    int          n, sh;
    @(posedge clk);
    valid  <= 1'b1;
    instr  <= ins;
    base   <= bv;
    cpu_be <= c[0];
    mem_be <= c[1];
    rev    <= c[2];
    dly    <= c[4:3];
    flt    <= c[6:5];
    cop_ok <= c[11:8];
    oldv   <= {$random(seed), $random(seed)};
    word   <= {$random(seed), $random(seed)};
    @(posedge clk);
    valid <= 1'b0;
    op  = ins[31:26];
    va  = bv + {{48{ins[15]}}, ins[15:0]};
    od  = (lv && lidx === ins[20:16]) ? ld : oldv;
    bt  = va[1:0] ^ {2{cpu_be}};
    wd  = (va[2] ^ cpu_be) ? word[63:32] : word[31:0];
    lft = op == `WLA_OPC_LEFT;
    rgt = op == `WLA_OPC_RIGHT;
    cop = op[5:2] == `WLA_OPC_COP;
    sh  = 8 * bt;
    t   = wd;
    ty  = (lft || rgt) ? {1'b0, bt} : cop ? `WLA_ACC_DWORD : `WLA_ACC_WORD;
    pa  = va[35:0] ^ ((lft || rgt) ? {33'h0, {3{rev}}} : {33'h0, rev, 2'h0});
    if ((lft && !mem_be) || (rgt && mem_be)) pa[2:0] = 3'h0;
    if (lft) t = (wd << (24 - sh)) | (od[31:0] & ((32'h1 << (24 - sh)) - 32'h1));
    if (rgt) t = (wd >> sh) | (od[31:0] & ~(32'hffffffff >> sh));
    if (op == `WLA_OPC_IMM) t = {ins[15:0], 16'h0};
    ed = {{32{t[31]}}, t};
    ek = wla_pkg::WLA_EXC_NONE;
    if (!(lft || rgt || cop || op == `WLA_OPC_IMM || op == `WLA_OPC_WORD) || op == 6'h30)
      ek = wla_pkg::WLA_EXC_RESERVED;
    else if (cop && !cop_ok[op[1:0]]) ek = wla_pkg::WLA_EXC_COP_UNUSABLE;
    else if ((cop || op == `WLA_OPC_WORD) && va[1:0] != 2'h0)
      ek = wla_pkg::WLA_EXC_ADDR_ERROR;
    else if (op != `WLA_OPC_IMM && flt != 2'h0)
      ek = wla_pkg::wla_exc_t'({1'b0, flt} + 3'h3);
    seen = 1'b0;
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge clk);
      if (mreq && !seen) begin
        seen = 1'b1;
        `CHK("paddr", pa, mpa)
        `CHK("offset", pa[2:0], moff)
        `CHK("type", ty, mtype)
      end
    end
    `CHK("done", 1'b1, done)
    `CHK("exc", ek != wla_pkg::WLA_EXC_NONE, evld)
    `CHK("kind", ek, ekind)
    `CHK("gpr_we", ek == wla_pkg::WLA_EXC_NONE && !cop, gwe)
    `CHK("cop_we", ek == wla_pkg::WLA_EXC_NONE && cop, cwe)
    if (ek == wla_pkg::WLA_EXC_ADDR_ERROR) `CHK("badva", va, eva)
    if (ek == wla_pkg::WLA_EXC_NONE && !cop) begin
      `CHK("gpr", ed, gdata)
      `CHK("idx", ins[20:16], gidx)
      lv   = 1'b1;
      lidx = ins[20:16];
      ld   = ed;
    end
    if (ek == wla_pkg::WLA_EXC_NONE && cop) begin
      `CHK("cop", wd, cdata)
      `CHK("sel", op[1:0], csel)
      `CHK("creg", ins[20:16], creg)
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    logic [5:0]  ops [9];
    logic [31:0] ins;
    logic [63:0] bv;
    logic [11:0] c;
    int          k;
    ops = '{`WLA_OPC_IMM, `WLA_OPC_WORD, `WLA_OPC_LEFT, `WLA_OPC_RIGHT,
            6'h30, 6'h31, 6'h32, 6'h33, 6'h3f};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    run({`WLA_OPC_IMM, 10'h1, 16'h8000}, 64'h0, 12'h0);
    run({`WLA_OPC_IMM, 10'h1, 16'h7fff}, 64'h0, 12'h0);
    // every start byte, both partial kinds, every cpu and memory endian mix
    for (k = 0; k < 64; k++) begin
      ins = $random(seed);
      ins[31:26] = k[3] ? `WLA_OPC_LEFT : `WLA_OPC_RIGHT;
      ins[20:18] = 3'h0;
      bv = {$random(seed), $random(seed)};
      bv[2:0] = k[2:0] - ins[2:0];
      c = 12'($random(seed));
      c[1:0] = k[5:4];
      c[6:5] = 2'h0;
      run(ins, bv, c);
    end
    // mixed traffic: faults, misalignment, coprocessor usability
    for (k = 0; k < 300; k++) begin
      ins = $random(seed);
      ins[31:26] = ops[{$random(seed)} % 9];
      ins[20:18] = 3'h0;
      bv = {$random(seed), $random(seed)};
      c = 12'($random(seed));
      if (c[7]) bv[1:0] = 2'h0 - ins[1:0];
      if (!(c[9] && c[10])) c[6:5] = 2'h0;
      run(ins, bv, c);
    end
    results();
  end
endmodule // word_load_align_unit_tb
